/* File: rtl/fetx_pkg.sv */
/*
  fetx_pkg: shared constants, types and the 4B/5B data map for the
  fast ethernet transmit encoder.
  Assumes one clock domain; one line bit leaves per clock cycle.
*/
package fetx_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int FETX_CLK_PERIOD_NS = 25;
  localparam int FETX_LINE_RATE_MBPS = 125; // nominal line rate, one bit per cycle here
  localparam int FETX_SYM_BITS = 5;
  localparam logic [2:0] FETX_BIT_LAST = 3'(FETX_SYM_BITS - 1);
  localparam logic [2:0] FETX_BIT_RST = 3'h0;

  // ----------------------------------------------------------------
  // code-groups
  // ----------------------------------------------------------------
  localparam logic [4:0] FETX_CODE_J = 5'h18;
  localparam logic [4:0] FETX_CODE_K = 5'h11;
  localparam logic [4:0] FETX_CODE_T = 5'h0D;
  localparam logic [4:0] FETX_CODE_R = 5'h07;
  localparam logic [4:0] FETX_CODE_IDLE = 5'h1F;
  localparam logic [4:0] FETX_CODE_HALT = 5'h04;
  localparam logic [4:0] FETX_CODE_LPI = 5'h00;
  localparam logic [3:0] FETX_NIB_LPI = 4'h1;

  // ----------------------------------------------------------------
  // scrambler
  // ----------------------------------------------------------------
  localparam int FETX_LFSR_W = 11;
  localparam int FETX_LFSR_TAP = 8; // x^9 term, counting from bit 0
  localparam logic [10:0] FETX_LFSR_SEED = 11'h7FF;

  // one nibble from the mac with its qualifiers
  typedef struct packed {
    logic en;
    logic er;
    logic [3:0] d;
  } fetx_mii_s;

  localparam int FETX_MII_W = $bits(fetx_mii_s);

  // transmit sequencer states
  typedef enum logic [2:0] {
    FETX_IDLE,
    FETX_SENT_J,
    FETX_DATA,
    FETX_SENT_T
  } fetx_state_e;

  // nibble to data code-group
  function automatic logic [4:0] fetx_enc(input logic [3:0] nib);
    logic [4:0] c;
    c = 5'h1E;
    unique case (nib)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction : fetx_enc

  // true for the unused patterns, never legal on the wire
  function automatic logic fetx_is_unused(input logic [4:0] c);
    return (c == 5'h01) || (c == 5'h02) || (c == 5'h03) || (c == 5'h05) ||
           (c == 5'h06) || (c == 5'h08) || (c == 5'h0C) || (c == 5'h10) ||
           (c == 5'h19);
  endfunction : fetx_is_unused

endpackage : fetx_pkg

/* File: rtl/fetx_buf2.sv */
/*
  fetx_buf2: small valid/ready buffer in front of the encoder.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module fetx_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // structure check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fetx_buf2 depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  // full when pointers differ only in the wrap bit
  always_comb
  begin
    in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
    out_valid = (wp_r != rp_r);
    out_data = mem_r[rp_r[AW-1:0]];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  // storage has no reset; only slots inside the pointers are read
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  // pointer registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

endmodule : fetx_buf2

/* File: rtl/fetx_encoder.sv */
/*
  fetx_encoder: 100 Mb/s transmit path - 4B/5B encoder with delimiter
  injection, 11-bit scrambler with bypass, NRZI and MLT-3 split.
  Assumes the mac drives nibbles on clk with valid/ready, config
  inputs are quasi-static and on clk, and line bits leave one per cycle.
*/
// Behaviour
// - map each nibble to its data code-group
// - start of frame sends J then K
// - later preamble and data nibbles are encoded
// - enable drop sends T then R
// - idle code-groups fill gaps between frames
// - halt code-group marks transmit error
// - error without enable, nibble 0001, sends LPI
// - control codes other than halt, or unused codes, in data flagged
// - scramble stream with closed-loop 11-bit LFSR
// - scrambler can be bypassed
// - NRZI encoding always applied, never bypassed
// - NRZI split into two alternating drive streams
// - copper output is MLT-3 only
// - full MLT-3 drive on both lines selectable
// - five line bits per nibble time
// - sequencing follows the standard transmit machine
// - fibre mode skips scrambler and MLT-3
`timescale 1ns/10ps
module fetx_encoder #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mac_valid,
  output logic mac_ready,
  input wire fetx_pkg::fetx_mii_s mac_word,
  input wire logic cfg_scr_bypass,
  input wire logic cfg_fx_mode,
  input wire logic cfg_full_mlt3,
  output logic line_p,
  output logic line_n,
  output logic tx_active,
  output logic code_err
);

  // ----------------------------------------------------------------
  // input buffer
  // ----------------------------------------------------------------
  logic buf_valid;
  logic [fetx_pkg::FETX_MII_W-1:0] buf_data;
  logic sym_tick;
  fetx_pkg::fetx_mii_s w;

  // drained only at symbol boundaries, so a fast mac really stalls
  fetx_buf2 #(
    .W(fetx_pkg::FETX_MII_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(mac_valid),
    .in_ready(mac_ready),
    .in_data(mac_word),
    .out_valid(buf_valid),
    .out_ready(sym_tick),
    .out_data(buf_data)
  );

  // an empty buffer reads as a quiet nibble (no enable, no error)
  always_comb
  begin
    w = buf_valid ? fetx_pkg::fetx_mii_s'(buf_data) : '0;
  end

  // ----------------------------------------------------------------
  // code-group sequencer
  // ----------------------------------------------------------------
  fetx_pkg::fetx_state_e state_r, state_nxt;
  logic [4:0] sym_r, sym_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic err_r, err_nxt;

  assign sym_tick = (bit_r == fetx_pkg::FETX_BIT_LAST);

  // one code-group per five cycles; state only moves at the boundary
  always_comb
  begin
    state_nxt = state_r;
    sym_nxt = sym_r;
    err_nxt = 1'b0;
    bit_nxt = sym_tick ? fetx_pkg::FETX_BIT_RST : bit_r + 3'h1;
    if (sym_tick)
    begin
      unique case (state_r)
        fetx_pkg::FETX_IDLE:
        begin
          if (w.en)
          begin
            sym_nxt = fetx_pkg::FETX_CODE_J;
            state_nxt = fetx_pkg::FETX_SENT_J;
          end
          else if (w.er && w.d == fetx_pkg::FETX_NIB_LPI)
          begin
            sym_nxt = fetx_pkg::FETX_CODE_LPI;
          end
          else
          begin
            sym_nxt = fetx_pkg::FETX_CODE_IDLE;
          end
        end
        fetx_pkg::FETX_SENT_J:
        begin
          // second preamble nibble is swallowed by K
          sym_nxt = fetx_pkg::FETX_CODE_K;
          state_nxt = fetx_pkg::FETX_DATA;
        end
        fetx_pkg::FETX_DATA:
        begin
          if (!w.en)
          begin
            sym_nxt = fetx_pkg::FETX_CODE_T;
            state_nxt = fetx_pkg::FETX_SENT_T;
          end
          else if (w.er)
          begin
            sym_nxt = fetx_pkg::FETX_CODE_HALT;
          end
          else
          begin
            sym_nxt = fetx_pkg::fetx_enc(w.d);
          end
        end
        fetx_pkg::FETX_SENT_T:
        begin
          // the mac's gap keeps enable low here; a nibble taken now is dropped
          sym_nxt = fetx_pkg::FETX_CODE_R;
          state_nxt = fetx_pkg::FETX_IDLE;
        end
      endcase
      // flag anything in a data slot that is not a data or halt code
      err_nxt = (state_r == fetx_pkg::FETX_DATA) && w.en &&
                (fetx_pkg::fetx_is_unused(sym_nxt) ||
                 (!w.er && sym_nxt != fetx_pkg::fetx_enc(w.d)));
    end
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_r <= fetx_pkg::FETX_IDLE;
      sym_r <= fetx_pkg::FETX_CODE_IDLE;
      bit_r <= fetx_pkg::FETX_BIT_RST;
      err_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sym_r <= sym_nxt;
      bit_r <= bit_nxt;
      err_r <= err_nxt;
    end
  end

  assign code_err = err_r;
  assign tx_active = (state_r != fetx_pkg::FETX_IDLE);

  // ----------------------------------------------------------------
  // scrambler, nrzi and mlt-3 line stage
  // ----------------------------------------------------------------
  logic code_bit, key_bit, scr_bit;
  logic [fetx_pkg::FETX_LFSR_W-1:0] lfsr_r, lfsr_nxt;
  logic nrzi_r, nrzi_nxt;
  logic phase_r, phase_nxt;
  logic p_r, p_nxt, n_r, n_nxt;
  logic mlt_p, mlt_n;

  // msb of the code-group leaves first
  always_comb
  begin
    code_bit = sym_r[3'(fetx_pkg::FETX_BIT_LAST - bit_r)];
    key_bit = lfsr_r[fetx_pkg::FETX_LFSR_W-1] ^ lfsr_r[fetx_pkg::FETX_LFSR_TAP];
    // fibre needs plain code-groups, so it overrides the bypass bit
    scr_bit = (cfg_scr_bypass || cfg_fx_mode) ? code_bit : code_bit ^ key_bit;
    // closed loop: lfsr runs free of the data, so it never locks at zero
    lfsr_nxt = {lfsr_r[fetx_pkg::FETX_LFSR_W-2:0], key_bit};
    nrzi_nxt = nrzi_r ^ scr_bit;
    // polarity flips each time a high run ends, so ones alternate lines
    phase_nxt = (nrzi_r && !nrzi_nxt) ? !phase_r : phase_r;
    mlt_p = nrzi_nxt && !phase_r;
    mlt_n = nrzi_nxt && phase_r;
    if (cfg_fx_mode)
    begin
      p_nxt = nrzi_nxt;
      n_nxt = !nrzi_nxt;
    end
    else if (cfg_full_mlt3)
    begin
      // both lines driven every bit: zero level shows as 1/1
      p_nxt = !mlt_n;
      n_nxt = !mlt_p;
    end
    else
    begin
      // no plain binary choice exists on copper
      p_nxt = mlt_p;
      n_nxt = mlt_n;
    end
  end

  // line registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      lfsr_r <= fetx_pkg::FETX_LFSR_SEED;
      nrzi_r <= 1'b0;
      phase_r <= 1'b0;
      p_r <= 1'b0;
      n_r <= 1'b0;
    end
    else
    begin
      lfsr_r <= lfsr_nxt;
      nrzi_r <= nrzi_nxt;
      phase_r <= phase_nxt;
      p_r <= p_nxt;
      n_r <= n_nxt;
    end
  end

  assign line_p = p_r;
  assign line_n = n_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_start_delim_pair: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_IDLE && w.en)
    |=> (sym_r == fetx_pkg::FETX_CODE_J) ##5 (sym_r == fetx_pkg::FETX_CODE_K))
    else $error("start delimiter J/K not sent");

  chk_data_nibble_map: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_DATA && w.en && !w.er)
    |=> (sym_r == fetx_pkg::fetx_enc($past(w.d))))
    else $error("data nibble mapped to wrong code-group");

  chk_data_after_k: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_SENT_J)
    |=> (state_r == fetx_pkg::FETX_DATA) [*5])
    else $error("sequencer left data phase after K");

  chk_end_delim_pair: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_DATA && !w.en)
    |=> (sym_r == fetx_pkg::FETX_CODE_T) ##5 (sym_r == fetx_pkg::FETX_CODE_R))
    else $error("end delimiter T/R not sent");

  chk_idle_fill: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_IDLE && !w.en && !w.er)
    |=> (sym_r == fetx_pkg::FETX_CODE_IDLE))
    else $error("gap not filled with idle");

  chk_halt_on_error: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_DATA && w.en && w.er)
    |=> (sym_r == fetx_pkg::FETX_CODE_HALT) && (state_r == fetx_pkg::FETX_DATA))
    else $error("transmit error did not send halt");

  chk_lpi_code: assert property (
    @(posedge clk) disable iff (!nrst)
    (sym_tick && state_r == fetx_pkg::FETX_IDLE && !w.en && w.er &&
     w.d == fetx_pkg::FETX_NIB_LPI)
    |=> (sym_r == fetx_pkg::FETX_CODE_LPI))
    else $error("low-power idle not coded");

  chk_no_bad_code: assert property (
    @(posedge clk) disable iff (!nrst)
    !fetx_pkg::fetx_is_unused(sym_r) && !code_err)
    else $error("invalid code-group on the wire");

  chk_scr_bypass: assert property (
    @(posedge clk) disable iff (!nrst)
    (cfg_scr_bypass || cfg_fx_mode) |=> (nrzi_r != $past(nrzi_r)) == $past(code_bit))
    else $error("bypassed stream was altered");

  chk_nrzi_follow: assert property (
    @(posedge clk) disable iff (!nrst)
    1'b1 |=> (nrzi_r ^ $past(nrzi_r)) == $past(scr_bit))
    else $error("nrzi level does not follow stream");

  chk_mlt3_lines: assert property (
    @(posedge clk) disable iff (!nrst)
    (!cfg_fx_mode && !cfg_full_mlt3) |=> !(line_p && line_n) && (line_p || line_n) == $past(nrzi_nxt))
    else $error("copper lines not mlt-3");

  chk_lfsr_alive: assert property (
    @(posedge clk) disable iff (!nrst)
    (lfsr_r != '0) && (lfsr_nxt[0] == (lfsr_r[10] ^ lfsr_r[8])))
    else $error("scrambler stuck or wrong taps");

  chk_symbol_rate: assert property (
    @(posedge clk) disable iff (!nrst)
    sym_tick |=> !sym_tick [*4] ##1 sym_tick)
    else $error("symbol boundary not every five bits");

endmodule : fetx_encoder

/* File: dv/fetx_mac_model.sv */
/*
  fetx_mac_model: mac side of the nibble port, offers one word at a time.
  Assumes the encoder buffer handshake on clk, mac_ready sampled at the edge.
*/
`timescale 1ns/10ps
module fetx_mac_model (
  input wire logic clk,
  input wire logic mac_ready,
  output logic mac_valid,
  output fetx_pkg::fetx_mii_s mac_word
);
  // ------------------------------------------------------------
  // drive state
  // ------------------------------------------------------------
  logic [5:0] junk_r = 6'h2A;
  fetx_pkg::fetx_mii_s word_r = 6'h00;

  // released word lines wander, so a stale nibble never passes for data
  always @(posedge clk)
    junk_r <= {junk_r[4:0], ~junk_r[5]};

  assign mac_word = mac_valid ? word_r : fetx_pkg::fetx_mii_s'(junk_r);

  initial
  begin
    mac_valid = 1'b0;
  end

  // offer a word and hold it until an edge sees the buffer take it
  task automatic send(input fetx_pkg::fetx_mii_s w, output bit ok);
    int n;
    mac_valid <= 1'b1;
    word_r <= w;
    ok = 1'b0;
    for (n = 0; n < 100 && !ok; n++)
    begin
      @(posedge clk);
      ok = (mac_ready === 1'b1);
    end
  endtask : send

  // release the port for a number of cycles
  task automatic rest(input int cycles);
    mac_valid <= 1'b0;
    repeat (cycles) @(posedge clk);
  endtask : rest
endmodule : fetx_mac_model

/* File: dv/fetx_encoder_bench.sv */
/*
  fetx_encoder_bench: self-checking bench for the transmit encoder.
  Assumes fetx_pkg and fetx_encoder from rtl/ and the mac model from dv/.
*/
`timescale 1ns/10ps
module fetx_encoder_bench;
  // ------------------------------------------------------------
  // clock, wiring, tables
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cfg_scr_bypass = 1'b0;
  logic cfg_fx_mode = 1'b0;
  logic cfg_full_mlt3 = 1'b0;
  logic mac_valid, mac_ready, line_p, line_n, tx_active, code_err;
  fetx_pkg::fetx_mii_s mac_word;
  int err_count = 0;
  int cmp_count = 0;
  // nibble beside its code-group
  localparam logic [8:0] ROWS [16] = '{9'h01E, 9'h029, 9'h054, 9'h075, 9'h08A, 9'h0AB,
    9'h0CE, 9'h0EF, 9'h112, 9'h133, 9'h156, 9'h177, 9'h19A, 9'h1BB, 9'h1DC, 9'h1FD};
  // line modes as {bypass, fibre, full drive}
  localparam logic [2:0] MODES [4] = '{3'b000, 3'b100, 3'b001, 3'b010};

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  fetx_mac_model mac (.clk(clk), .mac_ready(mac_ready), .mac_valid(mac_valid),
    .mac_word(mac_word));

  fetx_encoder #(.BUF_DEPTH(2)) dut (.clk(clk), .nrst(nrst), .mac_valid(mac_valid),
    .mac_ready(mac_ready), .mac_word(mac_word), .cfg_scr_bypass(cfg_scr_bypass),
    .cfg_fx_mode(cfg_fx_mode), .cfg_full_mlt3(cfg_full_mlt3), .line_p(line_p),
    .line_n(line_n), .tx_active(tx_active), .code_err(code_err));

  // ------------------------------------------------------------
  // line decoder
  // ------------------------------------------------------------
  logic nrzi, prev_nrzi, s, k, cb, plus, last_plus, seen_rise, synced, scr_on, saw_full;
  logic mon_on = 1'b0;
  logic [10:0] d_lfsr;
  logic [9:0] win;
  int train, bcnt;
  logic [4:0] got [$];
  logic [4:0] exp_q [$];

  // recover nrzi, undo scrambling, cut into code-groups once J/K is found;
  // the closed-loop scrambler is learnt from idle, so no seed phase is assumed
  always @(posedge clk)
  begin
    // error flag is unknown until the first reset edge has passed
    if (nrst && code_err !== 1'b0)
      check(16'(code_err), 16'h0);
    if (mac_valid && !mac_ready)
      saw_full = 1'b1;
    if (mon_on)
    begin
      nrzi = cfg_fx_mode ? line_p : (cfg_full_mlt3 ? ~(line_p & line_n) : (line_p | line_n));
      plus = cfg_full_mlt3 ? ~line_n : line_p;
      if (cfg_fx_mode)
        check(16'(line_n), 16'(!line_p));
      else if (cfg_full_mlt3)
        check(16'(line_p | line_n), 16'h1);
      else
        check(16'(line_p & line_n), 16'h0);
      if (!cfg_fx_mode && nrzi && !prev_nrzi)
      begin
        if (seen_rise)
          check(16'(plus), 16'(!last_plus));
        last_plus = plus;
        seen_rise = 1'b1;
      end
      s = nrzi ^ prev_nrzi;
      prev_nrzi = nrzi;
      k = (scr_on && train >= 16) ? d_lfsr[10] ^ d_lfsr[8] : ~s;
      cb = scr_on ? s ^ k : s;
      d_lfsr = {d_lfsr[9:0], k};
      train++;
      win = {win[8:0], cb};
      bcnt++;
      if (!synced && win == {fetx_pkg::FETX_CODE_J, fetx_pkg::FETX_CODE_K})
      begin
        synced = 1'b1;
        bcnt = 0;
        got.push_back(fetx_pkg::FETX_CODE_J);
        got.push_back(fetx_pkg::FETX_CODE_K);
      end
      else if (synced && bcnt == 5)
      begin
        bcnt = 0;
        if (win[4:0] != fetx_pkg::FETX_CODE_IDLE)
          got.push_back(win[4:0]);
      end
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic put(input fetx_pkg::fetx_mii_s w);
    bit ok;
    mac.send(w, ok);
    if (!ok)
    begin
      check(16'h0, 16'h1);
      summarize();
    end
  endtask : put

  // reset with a mode; outputs are looked at while reset still holds
  task automatic do_reset(input logic [2:0] m);
    mac.rest(1);
    mon_on = 1'b0;
    nrst <= 1'b0;
    {cfg_scr_bypass, cfg_fx_mode, cfg_full_mlt3} <= m;
    repeat (10) @(posedge clk);
    #1;
    check(16'({line_p, line_n, tx_active, code_err, mac_ready}), 16'h1);
    @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    scr_on = !m[2] && !m[1];
    prev_nrzi = 1'b0;
    seen_rise = 1'b0;
    synced = 1'b0;
    win = 10'h000;
    d_lfsr = 11'h000;
    train = 0;
    bcnt = 0;
    got.delete();
    exp_q.delete();
    mon_on = 1'b1;
    repeat (30) @(posedge clk);
    if (scr_on)
      check(16'(d_lfsr == 11'h000), 16'h0);
  endtask : do_reset

  // wait for the sequencer to go quiet, then compare decoded groups
  task automatic drain();
    int n;
    for (n = 0; n < 400 && tx_active !== 1'b0; n++)
      @(posedge clk);
    if (tx_active !== 1'b0)
    begin
      check(16'h0, 16'h1);
      summarize();
    end
    repeat (20) @(posedge clk);
    check(16'(got.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      if (i < got.size())
        check(16'(got[i]), 16'(exp_q[i]));
    got.delete();
    exp_q.delete();
  endtask : drain

  // two preamble nibbles become J/K, then the words, then T/R
  task automatic frame(input fetx_pkg::fetx_mii_s w [$]);
    exp_q.push_back(fetx_pkg::FETX_CODE_J);
    exp_q.push_back(fetx_pkg::FETX_CODE_K);
    put(6'h25);
    put(6'h25);
    foreach (w[i])
    begin
      exp_q.push_back(w[i].er ? fetx_pkg::FETX_CODE_HALT : ROWS[w[i].d][4:0]);
      put(w[i]);
    end
    exp_q.push_back(fetx_pkg::FETX_CODE_T);
    exp_q.push_back(fetx_pkg::FETX_CODE_R);
    mac.rest(1);
    #1;
    check(16'(tx_active), 16'h1);
    drain();
  endtask : frame

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    fetx_pkg::fetx_mii_s fw [$];
    foreach (ROWS[i])
      fw.push_back({2'b10, ROWS[i][8:5]});
    // every data row in four line modes, pushed back to back into the buffer
    foreach (MODES[m])
    begin
      do_reset(MODES[m]);
      saw_full = 1'b0;
      frame(fw);
      check(16'(saw_full), 16'h1);
      $display("test rows mode %b done", MODES[m]);
    end
    // reset in mid-frame: buffered words must not leak into the next frame
    put(6'h25);
    put(6'h25);
    put(6'h27);
    do_reset(3'b000);
    fw = '{6'h2A, 6'h30, 6'h23};
    frame(fw);
    $display("test reset and halt done");
    // error without enable carries the low-power idle nibble
    put(6'h11);
    exp_q.push_back(fetx_pkg::FETX_CODE_LPI);
    mac.rest(1);
    drain();
    $display("test low power idle done");
    summarize();
  end
endmodule : fetx_encoder_bench
